/* hdl/boot_cfg_pkg.sv */
// Constants for the boot configuration word loader.
// Assumes one 10 MHz system clock and a 32-bit Avalon-MM register bus.
package boot_cfg_pkg;
  localparam int unsigned WORD_W         = 32;
  localparam int unsigned ADDR_W         = 4;
  // Byte addresses of the registers
  localparam logic [3:0]  OFS_CFG_WORD   = 4'h0;
  localparam logic [3:0]  OFS_WDT_CTRL   = 4'h4;
  localparam logic [3:0]  OFS_STATUS     = 4'h8;
  // Field positions in the configuration word
  localparam int unsigned RSV_HI_MSB     = 31;
  localparam int unsigned RSV_HI_LSB     = 24;
  localparam int unsigned WDT_FUSE_BIT   = 23;
  localparam int unsigned RSV_LO_MSB     = 22;
  localparam int unsigned RSV_LO_LSB     = 21;
  localparam int unsigned WATCHDOG_POSTSCALE_SEL_MSB      = 20;
  localparam int unsigned WATCHDOG_POSTSCALE_SEL_LSB      = 16;
  localparam int unsigned CKSM_MSB       = 15;
  localparam int unsigned CKSM_LSB       = 14;
  localparam int unsigned POSC_MSB       = 9;
  localparam int unsigned POSC_LSB       = 8;
  localparam int unsigned PS_W           = 5;
  localparam logic [4:0]  PS_MAX_CODE    = 5'h14;
  localparam logic [1:0]  CKSM_SW_ONLY   = 2'h1;
  localparam logic [1:0]  POSC_DISABLED  = 2'h3;
  localparam logic [31:0] RSV_MASK       = 32'hFF60_0000;
  // Control register bit and status fields
  localparam int unsigned CTRL_WDT_ON    = 0;
  localparam int unsigned ST_WDT_RUN     = 0;
  localparam int unsigned ST_WDT_LOCK    = 1;
  localparam int unsigned ST_CLK_SW      = 2;
  localparam int unsigned ST_FSCM        = 3;
  localparam int unsigned ST_RSV_BAD     = 4;
  localparam int unsigned ST_POSC_OFF    = 5;
  localparam int unsigned ST_PS_LSB      = 8;
  localparam int unsigned ST_PS_MSB      = 12;
  localparam logic [31:0] READ_ZERO      = 32'h0000_0000;

  typedef enum logic [1:0] {
    LD_RESET = 2'b00,
    LD_SAMPLE = 2'b01,
    LD_READY = 2'b10
  } load_state_t;
endpackage

/* hdl/cfg_decode_if.sv */
// Carries the decoded configuration settings between loader and decoder.
// Assumes both ends sit on the same clock.
`timescale 1ns/10ps
`default_nettype none
interface cfg_decode_if;
  logic [31:0] word;
  logic        wdt_fuse;
  logic [4:0]  ps_code;
  logic        clk_switch_en;
  logic        fail_safe_en;
  logic        rsv_bad;
  logic        posc_off;
  modport loader  (output word, input wdt_fuse, ps_code, clk_switch_en, fail_safe_en,
                   rsv_bad, posc_off);
  modport decoder (input word, output wdt_fuse, ps_code, clk_switch_en, fail_safe_en,
                   rsv_bad, posc_off);
endinterface
`default_nettype wire

/* hdl/cfg_field_decode.sv */
// Pure decoder of the configuration word fields.
// Assumes the word is held stable by the loader between resets.
`timescale 1ns/10ps
`default_nettype none
module cfg_field_decode
  import boot_cfg_pkg::*;
(
  cfg_decode_if.decoder dec
);
  logic [1:0] cksm;
  logic [4:0] ps_raw;

  assign ps_raw = dec.word[WATCHDOG_POSTSCALE_SEL_MSB:WATCHDOG_POSTSCALE_SEL_LSB];
  assign cksm   = dec.word[CKSM_MSB:CKSM_LSB];
  assign dec.wdt_fuse      = dec.word[WDT_FUSE_BIT];
  // Undefined codes behave as the largest ratio
  assign dec.ps_code       = (ps_raw > PS_MAX_CODE) ? PS_MAX_CODE : ps_raw;
  // Upper bit set kills both; 01 switching only; 00 both
  assign dec.clk_switch_en = ~cksm[1];
  assign dec.fail_safe_en  = ~cksm[1] & (cksm != CKSM_SW_ONLY);
  // Flag only: the device cannot repair a badly programmed word
  assign dec.rsv_bad       = (dec.word & RSV_MASK) != RSV_MASK;
  assign dec.posc_off      = dec.word[POSC_MSB:POSC_LSB] == POSC_DISABLED;
endmodule
`default_nettype wire

/* hdl/boot_config_word_watchdog_clock.sv */
// Loader for the boot configuration word with watchdog and clock policy outputs.
// Assumes i_nv_word is stable from the nonvolatile array while reset is asserted.
//
// Local design decisions: the Avalon-MM slave port and the register offsets.
`timescale 1ns/10ps
`default_nettype none
module boot_config_word_watchdog_clock
  import boot_cfg_pkg::*;
(
  input  wire logic              i_ref_clk,
  input  wire logic              i_rst_n,
  input  wire logic [31:0]       i_nv_word,
  input  wire logic [ADDR_W-1:0] i_avs_address,
  input  wire logic              i_avs_read,
  input  wire logic              i_avs_write,
  input  wire logic [31:0]       i_avs_writedata,
  input  wire logic [3:0]        i_avs_byteenable,
  output logic [31:0]            o_avs_readdata,
  output logic                   o_avs_waitrequest,
  output logic                   o_cfg_ready,
  output logic                   o_wdt_enable,
  output logic [4:0]             o_wdt_postscale,
  output logic [20:0]            o_wdt_ratio,
  output logic                   o_clk_switch_en,
  output logic                   o_fail_safe_en
);
  load_state_t  state_q;
  logic [31:0]  word_q;
  logic         sw_wdt_on_q;
  logic         ack_q;
  logic [31:0]  status;
  logic         req;

  cfg_decode_if dec_bus ();

  cfg_field_decode u_decode (
    .dec (dec_bus.decoder)
  );

  assign dec_bus.word = word_q;

  // Sample one cycle after release so the strap is a clocked capture
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_q <= LD_RESET;
    end else begin
      case (state_q)
        LD_RESET:  state_q <= LD_SAMPLE;
        LD_SAMPLE: state_q <= LD_READY;
        LD_READY:  state_q <= LD_READY;
        default:   state_q <= LD_RESET;
      endcase
    end
  end

  // Captured once; no later path rewrites it
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      word_q <= READ_ZERO;
    end else if (state_q == LD_SAMPLE) begin
      word_q <= i_nv_word;
    end
  end

  assign o_cfg_ready = (state_q == LD_READY);

  // Single-cycle wait state; answer comes on the second edge after the request
  assign req               = i_avs_read | i_avs_write;
  assign o_avs_waitrequest = req & ~ack_q;

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= req & ~ack_q;
    end
  end

  // Software enable; only a low fuse lets it matter
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sw_wdt_on_q <= 1'b0;
    end else if (i_avs_write && ack_q && i_avs_byteenable[0]
                 && i_avs_address == OFS_WDT_CTRL) begin
      sw_wdt_on_q <= i_avs_writedata[CTRL_WDT_ON];
    end
  end

  // Fuse forces run; a software clear cannot override it
  assign o_wdt_enable    = o_cfg_ready & (dec_bus.wdt_fuse | sw_wdt_on_q);
  assign o_wdt_postscale = dec_bus.ps_code;
  assign o_wdt_ratio     = 21'(1) << dec_bus.ps_code;
  assign o_clk_switch_en = o_cfg_ready & dec_bus.clk_switch_en;
  assign o_fail_safe_en  = o_cfg_ready & dec_bus.fail_safe_en;

  always_comb begin
    status = READ_ZERO;
    status[ST_WDT_RUN]            = o_wdt_enable;
    status[ST_WDT_LOCK]           = dec_bus.wdt_fuse;
    status[ST_CLK_SW]             = o_clk_switch_en;
    status[ST_FSCM]               = o_fail_safe_en;
    status[ST_RSV_BAD]            = dec_bus.rsv_bad & o_cfg_ready;
    status[ST_POSC_OFF]           = dec_bus.posc_off;
    status[ST_PS_MSB:ST_PS_LSB]   = dec_bus.ps_code;
  end

  // Read data registered at the wait-state edge, one before the answering edge; unmapped reads give zero
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_avs_readdata <= READ_ZERO;
    end else if (i_avs_read && !ack_q) begin
      case (i_avs_address)
        OFS_CFG_WORD: o_avs_readdata <= word_q;
        OFS_WDT_CTRL: o_avs_readdata <= {31'h0000_0000, sw_wdt_on_q};
        OFS_STATUS:   o_avs_readdata <= status;
        default:      o_avs_readdata <= READ_ZERO;
      endcase
    end
  end
endmodule
`default_nettype wire

/* test/boot_cfg_assertions.sv */
// Checker for the boot configuration loader, bound to its top module.
// Assumes the configuration word is stable until the loader reports ready.
`timescale 1ns/10ps
`default_nettype none
module boot_cfg_checker (
  input wire logic        i_ref_clk,
  input wire logic        i_rst_n,
  input wire logic [31:0] i_nv_word,
  input wire logic        o_cfg_ready,
  input wire logic        o_wdt_enable,
  input wire logic [4:0]  o_wdt_postscale,
  input wire logic [20:0] o_wdt_ratio,
  input wire logic        o_clk_switch_en,
  input wire logic        o_fail_safe_en
);
  logic [31:0] word_q;
  // Frozen at ready, so later word changes cannot mask a missed capture
  always_ff @(posedge i_ref_clk) if (!o_cfg_ready) word_q <= i_nv_word;
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_n);
  sequence s_boot;
    !o_cfg_ready ##[1:2] o_cfg_ready;
  endsequence
  a_ready_boot: assert property ($rose(i_rst_n) |-> s_boot)
    else $error("ready not raised after reset");
  a_fuse_lock: assert property (o_cfg_ready && word_q[23] |-> o_wdt_enable)
    else $error("watchdog off with fuse set");
  a_fuse_clear: assert property ($rose(o_cfg_ready) && !word_q[23] |-> !o_wdt_enable)
    else $error("watchdog on after boot with fuse clear");
  a_ps_clamp: assert property (o_cfg_ready |-> o_wdt_postscale ==
    (word_q[20:16] > 5'h14 ? 5'h14 : word_q[20:16])) else $error("postscale code wrong");
  a_ratio_pow: assert property (o_cfg_ready |-> o_wdt_ratio == (21'h1 << o_wdt_postscale))
    else $error("ratio not a power of two of code");
  a_clk_policy: assert property (o_cfg_ready |-> {o_clk_switch_en, o_fail_safe_en} ==
    (word_q[15] ? 2'h0 : {1'b1, !word_q[14]})) else $error("clock policy wrong");
  a_cfg_hold: assert property (o_cfg_ready |=> $stable(o_wdt_postscale) &&
    $stable(o_clk_switch_en) && $stable(o_fail_safe_en)) else $error("settings changed");
endmodule
`default_nettype wire

/* test/testbench.sv */
// Self-checking bench for the boot configuration loader.
// Assumes the design package and the checker are compiled first.
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import boot_cfg_pkg::*;
  logic        i_ref_clk = 1'b0;
  logic        i_rst_n = 1'b0;
  logic [31:0] i_nv_word = 32'hFF60_0000;
  logic [3:0]  i_avs_address = 4'h0;
  logic        i_avs_read = 1'b0;
  logic        i_avs_write = 1'b0;
  logic [31:0] i_avs_writedata = 32'h0000_0000;
  logic [31:0] o_avs_readdata;
  logic        o_avs_waitrequest, o_cfg_ready, o_wdt_enable, o_clk_switch_en, o_fail_safe_en;
  logic [4:0]  o_wdt_postscale;
  logic [20:0] o_wdt_ratio;
  logic [31:0] q;
  int          mismatches = 0;
  int          total_checks = 0;
  always #50 i_ref_clk = ~i_ref_clk;
  boot_config_word_watchdog_clock dut_u (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n),
    .i_nv_word(i_nv_word), .i_avs_address(i_avs_address), .i_avs_read(i_avs_read),
    .i_avs_write(i_avs_write), .i_avs_writedata(i_avs_writedata), .i_avs_byteenable(4'hF),
    .o_avs_readdata(o_avs_readdata), .o_avs_waitrequest(o_avs_waitrequest),
    .o_cfg_ready(o_cfg_ready), .o_wdt_enable(o_wdt_enable), .o_wdt_postscale(o_wdt_postscale),
    .o_wdt_ratio(o_wdt_ratio), .o_clk_switch_en(o_clk_switch_en), .o_fail_safe_en(o_fail_safe_en));
  task automatic chk(input logic [31:0] s, input logic [31:0] e, input string n);
    total_checks++;
    if (s !== e) begin
      mismatches++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic avs(input logic w, input logic [3:0] a, input logic [31:0] d);
    logic wr;
    i_avs_read <= !w;
    i_avs_write <= w;
    i_avs_address <= a;
    i_avs_writedata <= d;
    // Judge waitrequest settled mid-cycle; the next rising edge is the answering one
    do begin
      @(negedge i_ref_clk);
      wr = o_avs_waitrequest;
      q = o_avs_readdata;
      @(posedge i_ref_clk);
    end while (wr !== 1'b0);
    i_avs_read <= 1'b0;
    i_avs_write <= 1'b0;
    @(posedge i_ref_clk);
  endtask
  task automatic boot(input logic [31:0] w);
    i_rst_n <= 1'b0;
    i_nv_word <= w;
    repeat (3) @(posedge i_ref_clk);
    i_rst_n <= 1'b1;
    repeat (4) @(posedge i_ref_clk);
    chk(o_cfg_ready, 1, "cfg_ready");
  endtask
  task automatic test_lock;
    boot(32'hFFF4_4000);
    avs(1'b1, OFS_WDT_CTRL, 32'h0000_0000);
    chk(o_wdt_enable, 1, "wdt_enable");
    i_nv_word <= 32'h0000_0000;
    avs(1'b0, OFS_CFG_WORD, 0);
    chk(q, 32'hFFF4_4000, "cfg_word");
    chk({o_wdt_ratio, o_clk_switch_en, o_fail_safe_en}, 23'h40_0002, "settings");
    avs(1'b0, OFS_STATUS, 0);
    chk(q, 32'h0000_1407, "status");
    avs(1'b0, 4'hC, 0);
    chk(q, 0, "unmapped");
    $display("test_lock done");
  endtask
  task automatic test_soft;
    boot(32'hFF60_0000);
    chk(o_wdt_enable, 0, "wdt_off");
    avs(1'b1, OFS_WDT_CTRL, 32'h0000_0001);
    chk(o_wdt_enable, 1, "wdt_sw_on");
    $display("test_soft done");
  endtask
  task automatic test_codes;
    logic [4:0] e;
    for (int c = 0; c < 32; c++) begin
      boot(32'hFF60_0000 | (c << 16) | ((c % 4) << 14));
      e = (c > 20) ? 5'h14 : 5'(c);
      chk(o_wdt_postscale, e, "postscale");
      chk(o_wdt_ratio, 21'h1 << e, "ratio");
      chk({o_clk_switch_en, o_fail_safe_en}, (c % 4) > 1 ? 0 : 3 - (c % 4), "clk");
    end
    $display("test_codes done");
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    test_lock;
    test_soft;
    test_codes;
    finish_test;
  end
  initial begin
    repeat (5000) @(posedge i_ref_clk);
    mismatches++;
    finish_test;
  end
endmodule
bind boot_config_word_watchdog_clock boot_cfg_checker chk_u (.i_ref_clk(i_ref_clk),
  .i_rst_n(i_rst_n), .i_nv_word(i_nv_word), .o_cfg_ready(o_cfg_ready),
  .o_wdt_enable(o_wdt_enable), .o_wdt_postscale(o_wdt_postscale), .o_wdt_ratio(o_wdt_ratio),
  .o_clk_switch_en(o_clk_switch_en), .o_fail_safe_en(o_fail_safe_en));
`default_nettype wire
